//--- src/rpm_top.sv
// receive pattern matcher tail: registers, avalon slave and byte matcher
// Summary of operation
// - A writable 16-bit register holds pattern bytes 60 and 61.
// - A writable 16-bit register holds pattern bytes 62 and 63, the last two.
// - A mask bit of one excludes its pattern byte from comparison, zero includes it.
// - The first mask register covers bytes 0 to 15 and resets to zero.
// - The second mask register covers bytes 16 to 31 and resets to zero.
// - The third mask register covers bytes 32 to 47 and resets to zero.
// - The fourth mask register covers bytes 48 to 63 and resets to zero.
// - A 6-bit start point in bits 5:0 sets the byte after the delimiter where comparison starts.
// - Start point 0 starts at the first byte after the delimiter, 63 at the sixty-fourth.
// - Bits 15:6 of the start point register ignore writes and read zero.
// - Pattern bytes sit two per register at consecutive addresses.
module rpm_top
(
    input  wire logic                   sys_clk,
    input  wire logic                   arst_n,
    input  wire logic [11:0]            avs_address,
    input  wire logic                   avs_read,
    input  wire logic                   avs_write,
    input  wire logic [31:0]            avs_writedata,
    input  wire logic [3:0]             avs_byteenable,
    output logic [31:0]                 avs_readdata,
    output logic                        avs_waitrequest,
    output logic [1:0]                  avs_response,
    input  wire logic [8*rpm_pkg::HEAD_BYTES-1:0] head_pattern,
    input  wire logic                   rx_sfd,
    input  wire logic                   rx_valid,
    input  wire logic [7:0]             rx_data,
    input  wire logic                   rx_end,
    output logic                        match_pulse,
    output logic                        match_done,
    output logic [8*rpm_pkg::TAIL_BYTES-1:0] tail_pattern,
    output logic [rpm_pkg::PAT_BYTES-1:0]    byte_mask
);
    import rpm_pkg::*;

    logic [15:0]      pattern_60_61;
    logic [15:0]      pattern_62_63;
    logic [15:0]      mask_word [4];
    logic [5:0]       start_point;
    logic             acc_done;
    logic [9:0]       reg_idx;
    logic             idx_ok;
    logic [15:0]      rd_word;
    logic [15:0]      wr_mask;
    logic [15:0]      next_word;
    rpm_state_t       state;
    logic [5:0]       skip_cnt;
    logic [5:0]       cmp_idx;
    logic             all_hit;
    logic [7:0]       full_pat [PAT_BYTES];
    logic [PAT_BYTES-1:0] mask_flat;
    logic [PAT_BYTES-1:0] hit_vec;

    // word index from the byte address, low two bits ignored
    assign reg_idx = avs_address[11:2];
    assign wr_mask = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

    // address decode of mapped registers
    always_comb
    begin
        idx_ok  = 1'b1;
        rd_word = 16'h0000;
        unique case (reg_idx)
            IDX_PAT_60_61:   rd_word = pattern_60_61;
            IDX_PAT_62_63:   rd_word = pattern_62_63;
            IDX_MASK_0_15:   rd_word = mask_word[0];
            IDX_MASK_16_31:  rd_word = mask_word[1];
            IDX_MASK_32_47:  rd_word = mask_word[2];
            IDX_MASK_48_63:  rd_word = mask_word[3];
            IDX_START_POINT: rd_word = {10'h000, start_point};
            default:         idx_ok  = 1'b0;
        endcase
    end

    // byte-enable merge of write data into the old word
    assign next_word = (avs_writedata[15:0] & wr_mask) | (rd_word & ~wr_mask);

    // one wait cycle per access: waitrequest low on the second cycle
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
            acc_done <= 1'b0;
        else
            acc_done <= (avs_read | avs_write) & ~acc_done;
    end

    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
            avs_waitrequest <= 1'b1;
        else
            avs_waitrequest <= ~((avs_read | avs_write) & ~acc_done);
    end

    // read data and response registered with the answer
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            avs_readdata <= 32'h0000_0000;
            avs_response <= 2'b00;
        end
        else if ((avs_read | avs_write) & ~acc_done)
        begin
            avs_readdata <= avs_read ? {16'h0000, rd_word} : 32'h0000_0000;
            avs_response <= idx_ok ? 2'b00 : 2'b11; // decode error when unmapped
        end
    end

    // pattern tail registers, written at the sampling edge
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            pattern_60_61 <= RST_PATTERN;
            pattern_62_63 <= RST_PATTERN;
        end
        else if (avs_write & acc_done)
        begin
            if (reg_idx == IDX_PAT_60_61)
                pattern_60_61 <= next_word;
            if (reg_idx == IDX_PAT_62_63)
                pattern_62_63 <= next_word;
        end
    end

    // byte mask registers, cleared at reset
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            for (int i = 0; i < 4; i++)
                mask_word[i] <= RST_MASK;
        end
        else if (avs_write & acc_done)
        begin
            if (reg_idx == IDX_MASK_0_15)
                mask_word[0] <= next_word;
            if (reg_idx == IDX_MASK_16_31)
                mask_word[1] <= next_word;
            if (reg_idx == IDX_MASK_32_47)
                mask_word[2] <= next_word;
            if (reg_idx == IDX_MASK_48_63)
                mask_word[3] <= next_word;
        end
    end

    // start point, only the low six bits are stored
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
            start_point <= RST_START;
        else if (avs_write & acc_done & (reg_idx == IDX_START_POINT) & avs_byteenable[0])
            start_point <= avs_writedata[START_W-1:0];
    end

    // flat mask and pattern vectors, sixteen mask bits or two pattern bytes per word
    assign mask_flat = {mask_word[3], mask_word[2], mask_word[1], mask_word[0]};

    genvar g;
    generate
        for (g = 0; g < PAT_BYTES; g++)
        begin : gen_byte
            if (g < HEAD_BYTES)
            begin : gen_head
                assign full_pat[g] = head_pattern[8*g +: 8];
            end
            else if (g < HEAD_BYTES + 2)
            begin : gen_t0
                assign full_pat[g] = pattern_60_61[(g % 2 == 0 ? LO_BYTE_LSB : HI_BYTE_LSB) +: 8];
            end
            else
            begin : gen_t1
                assign full_pat[g] = pattern_62_63[(g % 2 == 0 ? LO_BYTE_LSB : HI_BYTE_LSB) +: 8];
            end
            rpm_byte_cmp u_cmp
            (
                .pat_byte (full_pat[g]),
                .rx_byte  (rx_data),
                .mask_bit (mask_flat[g]),
                .hit      (hit_vec[g])
            );
        end
    endgenerate

    // frame walker: skip to start point, then compare 64 bytes
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state    <= RPM_IDLE;
            skip_cnt <= 6'h00;
            cmp_idx  <= 6'h00;
            all_hit  <= 1'b0;
        end
        else if (rx_sfd)
        begin
            state    <= (start_point == 6'h00) ? RPM_COMPARE : RPM_SKIP;
            skip_cnt <= start_point;
            cmp_idx  <= 6'h00;
            all_hit  <= 1'b1;
        end
        else
        begin
            unique case (state)
                RPM_IDLE:
                    state <= RPM_IDLE;
                RPM_SKIP:
                    if (rx_end)
                        state <= RPM_IDLE;
                    else if (rx_valid)
                    begin
                        skip_cnt <= skip_cnt - 6'h01;
                        if (skip_cnt == 6'h01)
                            state <= RPM_COMPARE;
                    end
                RPM_COMPARE:
                    if (rx_end)
                        state <= RPM_IDLE;
                    else if (rx_valid)
                    begin
                        all_hit <= all_hit & hit_vec[cmp_idx];
                        cmp_idx <= cmp_idx + 6'h01;
                        if (cmp_idx == 6'h3F)
                            state <= RPM_DONE;
                    end
                RPM_DONE:
                    state <= RPM_IDLE;
            endcase
        end
    end

    // result outputs registered
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            match_pulse <= 1'b0;
            match_done  <= 1'b0;
        end
        else
        begin
            match_done  <= (state == RPM_DONE);
            match_pulse <= (state == RPM_DONE) & all_hit;
        end
    end

    // stored tail and mask exported to the rest of the matcher
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            tail_pattern <= 32'h0000_0000;
            byte_mask    <= 64'h0000_0000_0000_0000;
        end
        else
        begin
            tail_pattern <= {pattern_62_63, pattern_60_61};
            byte_mask    <= mask_flat;
        end
    end

    mask_reset_a: assert property (@(posedge sys_clk)
        $rose(arst_n) |-> byte_mask == 64'h0)
        else $error("mask not zero after reset");
    start_upper_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (avs_read & ~avs_waitrequest & (reg_idx == IDX_START_POINT)) |-> avs_readdata[15:6] == 10'h0)
        else $error("start point upper bits not zero");
    tail_write_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (avs_write & acc_done & (reg_idx == IDX_PAT_60_61) & (avs_byteenable[1:0] == 2'b11))
        |=> ##1 tail_pattern[15:0] == $past(avs_writedata[15:0], 2))
        else $error("pattern 60 61 not stored");
    match_done_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        match_pulse |-> match_done)
        else $error("match without done");
    skip_len_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (state == RPM_SKIP && skip_cnt == 6'h01 && rx_valid && !rx_end && !rx_sfd)
        |=> state == RPM_COMPARE)
        else $error("skip did not end at start point");
    zero_start_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (rx_sfd && start_point == 6'h00) |=> state == RPM_COMPARE && cmp_idx == 6'h00)
        else $error("zero start point not immediate");
    tail_hi_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (avs_write & acc_done & (reg_idx == IDX_PAT_62_63) & (avs_byteenable[1:0] == 2'b11))
        |=> ##1 tail_pattern[31:16] == $past(avs_writedata[15:0], 2))
        else $error("pattern 62 63 not stored");
    mask_all_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (state == RPM_DONE && mask_flat == 64'hFFFF_FFFF_FFFF_FFFF && $stable(all_hit) && all_hit)
        |=> match_pulse)
        else $error("fully masked frame not matched");
    mask_first_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (avs_write & acc_done & (reg_idx == IDX_MASK_0_15) & (avs_byteenable[1:0] == 2'b11))
        |=> ##1 byte_mask[15:0] == $past(avs_writedata[15:0], 2))
        else $error("mask 0 15 not stored");
    mask_second_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (avs_write & acc_done & (reg_idx == IDX_MASK_16_31) & (avs_byteenable[1:0] == 2'b11))
        |=> ##1 byte_mask[31:16] == $past(avs_writedata[15:0], 2))
        else $error("mask 16 31 not stored");
    mask_third_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (avs_write & acc_done & (reg_idx == IDX_MASK_32_47) & (avs_byteenable[1:0] == 2'b11))
        |=> ##1 byte_mask[47:32] == $past(avs_writedata[15:0], 2))
        else $error("mask 32 47 not stored");
    mask_fourth_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (avs_write & acc_done & (reg_idx == IDX_MASK_48_63) & (avs_byteenable[1:0] == 2'b11))
        |=> ##1 byte_mask[63:48] == $past(avs_writedata[15:0], 2))
        else $error("mask 48 63 not stored");
    start_store_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (avs_write & acc_done & (reg_idx == IDX_START_POINT) & avs_byteenable[0])
        |=> start_point == $past(avs_writedata[5:0]))
        else $error("start point not stored");
    done_pulse_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        match_done |=> !match_done)
        else $error("done longer than one cycle");
    masked_keep_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (state == RPM_COMPARE && rx_valid && !rx_end && !rx_sfd && mask_flat[cmp_idx])
        |=> all_hit == $past(all_hit))
        else $error("masked byte changed the result");
    miss_clear_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (state == RPM_COMPARE && rx_valid && !rx_end && !rx_sfd && !mask_flat[cmp_idx]
            && full_pat[cmp_idx] != rx_data) |=> !all_hit)
        else $error("unmasked miss not seen");
    abort_idle_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (state != RPM_IDLE && rx_end && !rx_sfd) |=> state == RPM_IDLE)
        else $error("aborted frame still walking");
endmodule

//--- pkg/rpm_pkg.sv
// constants and types shared by the receive pattern matcher tail
package rpm_pkg;
    // register indices as printed; byte address is four times the index
    localparam logic [9:0]  IDX_PAT_60_61    = 10'h15A;
    localparam logic [9:0]  IDX_PAT_62_63    = 10'h15B;
    localparam logic [9:0]  IDX_MASK_0_15    = 10'h15C;
    localparam logic [9:0]  IDX_MASK_16_31   = 10'h15D;
    localparam logic [9:0]  IDX_MASK_32_47   = 10'h15E;
    localparam logic [9:0]  IDX_MASK_48_63   = 10'h15F;
    localparam logic [9:0]  IDX_START_POINT  = 10'h161;
    // reset values
    localparam logic [15:0] RST_PATTERN      = 16'h0000;
    localparam logic [15:0] RST_MASK         = 16'h0000;
    localparam logic [5:0]  RST_START        = 6'h00;
    // field layout
    localparam int          START_W          = 6;
    localparam int          PAT_BYTES        = 64;
    localparam int          TAIL_BYTES       = 4;
    localparam int          HEAD_BYTES       = 60;
    localparam int          LO_BYTE_LSB      = 0;
    localparam int          HI_BYTE_LSB      = 8;
    // matcher states
    typedef enum logic [1:0]
    {
        RPM_IDLE    = 2'b00,
        RPM_SKIP    = 2'b01,
        RPM_COMPARE = 2'b10,
        RPM_DONE    = 2'b11
    } rpm_state_t;
endpackage

//--- src/rpm_byte_cmp.sv
// one pattern byte compared against one received byte under its mask
module rpm_byte_cmp
(
    input  wire logic [7:0] pat_byte,
    input  wire logic [7:0] rx_byte,
    input  wire logic       mask_bit,
    output logic            hit
);
    import rpm_pkg::*;
    // masked byte always counts as matching
    // mask excludes byte
    assign hit = mask_bit | (pat_byte == rx_byte);
endmodule

//--- bench/rpm_frame_src.sv
// link partner model: sends one received frame after a delimiter
module rpm_frame_src
(
    input  wire logic  clk,
    output logic       rx_sfd   = 1'b0,
    output logic       rx_valid = 1'b0,
    output logic [7:0] rx_data  = 8'h00,
    output logic       rx_end   = 1'b0
);
    timeunit 1ns;
    timeprecision 1ps;

    // delimiter, skipped bytes, then 64 pattern bytes; bad flips one byte, cut aborts
    task automatic send(input logic [5:0] skip, input logic [511:0] pat, input int bad,
                        input int cut);
        int i;
        rx_sfd <= 1'b1;
        @(posedge clk);
        rx_sfd <= 1'b0;
        for (i = 0; i < skip + 64; i++)
        begin
            // a negative cut means the frame runs to its end
            if (cut >= 0 && i == skip + cut)
            begin
                rx_end   <= 1'b1;
                rx_valid <= 1'b0;
                @(posedge clk);
                rx_end   <= 1'b0;
                return;
            end
            rx_valid <= 1'b1;
            if (i < skip)
                rx_data <= 8'h5A ^ i[7:0];
            else
                rx_data <= pat[8*(i-skip)+:8] ^ ((i - skip == bad) ? 8'hFF : 8'h00);
            @(posedge clk);
        end
        // idle data line shows no stale byte
        rx_valid <= 1'b0;
        rx_data  <= ~rx_data;
        @(posedge clk);
    endtask
endmodule

//--- bench/rpm_top_test.sv
// self-checking bench for the receive pattern matcher tail
module rpm_top_test;
    timeunit 1ns;
    timeprecision 1ps;
    import rpm_pkg::*;

    logic         sys_clk = 1'b0;
    logic         arst_n  = 1'b0;
    logic [11:0]  avs_address = 12'h000;
    logic         avs_read = 1'b0;
    logic         avs_write = 1'b0;
    logic [31:0]  avs_writedata = 32'h0;
    logic [3:0]   avs_byteenable = 4'hF;
    logic [31:0]  avs_readdata;
    logic         avs_waitrequest;
    logic [1:0]   avs_response;
    logic [479:0] head_pattern = '0;
    logic         rx_sfd, rx_valid, rx_end, match_pulse, match_done;
    logic [7:0]   rx_data;
    logic [31:0]  tail_pattern;
    logic [63:0]  byte_mask;
    logic [33:0]  rd_q[$];
    logic         mt_q[$];
    logic [15:0]  regs[7];
    logic [9:0]   idx_t[7] = '{IDX_PAT_60_61, IDX_PAT_62_63, IDX_MASK_0_15, IDX_MASK_16_31,
                               IDX_MASK_32_47, IDX_MASK_48_63, IDX_START_POINT};
    int           n_errors = 0;
    int           check_count = 0;
    int           seed = 32'h07b7f519;
    int           i, b;
    logic [5:0]   sp;

    rpm_top rpm_top_i (.sys_clk(sys_clk), .arst_n(arst_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .avs_response(avs_response),
        .head_pattern(head_pattern), .rx_sfd(rx_sfd), .rx_valid(rx_valid), .rx_data(rx_data),
        .rx_end(rx_end), .match_pulse(match_pulse), .match_done(match_done),
        .tail_pattern(tail_pattern), .byte_mask(byte_mask));
    rpm_frame_src rpm_frame_src_i (.clk(sys_clk), .rx_sfd(rx_sfd), .rx_valid(rx_valid),
        .rx_data(rx_data), .rx_end(rx_end));

    // clock, 8 ns period
    initial
    begin
        forever #4 sys_clk = ~sys_clk;
    end

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        check_count++;
        if (got !== exp)
        begin
            n_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // one avalon access, held until waitrequest is sampled low
    task automatic bus(input logic w, input logic [9:0] idx, input logic [15:0] d);
        int n;
        avs_address   <= {idx, 2'b00};
        avs_write     <= w;
        avs_read      <= ~w;
        avs_writedata <= {16'h0000, d};
        n = 0;
        do
        begin
            @(posedge sys_clk);
            n++;
        end
        while (avs_waitrequest !== 1'b0 && n < 20);
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
        @(posedge sys_clk);
        if (n >= 20)
        begin
            n_errors++;
            wrap_up();
        end
    endtask

    task automatic rd(input logic [9:0] idx, input logic [33:0] exp);
        rd_q.push_back(exp);
        bus(1'b0, idx, 16'h0000);
    endtask

    task automatic frame(input int bad, input int cut, input logic exp);
        int n;
        if (cut < 0)
            mt_q.push_back(exp);
        rpm_frame_src_i.send(sp, {regs[1], regs[0], head_pattern}, bad, cut);
        n = 0;
        while (mt_q.size() != 0 && n < 10)
        begin
            @(posedge sys_clk);
            n++;
        end
        if (n >= 10)
        begin
            n_errors++;
            wrap_up();
        end
    endtask

    // monitor: read data and match results against the oldest note
    always @(posedge sys_clk)
    begin
        if (avs_read && avs_waitrequest === 1'b0 && rd_q.size() > 0)
            chk({30'h0, avs_response, avs_readdata}, {30'h0, rd_q.pop_front()});
        if (match_pulse === 1'b1 && match_done !== 1'b1)
            chk(64'h1, 64'h0);
        if (match_done === 1'b1)
        begin
            if (mt_q.size() == 0)
                chk(64'h1, 64'h0);
            else
                chk({63'h0, match_pulse}, {63'h0, mt_q.pop_front()});
        end
    end

    // main sequence
    initial
    begin
        for (i = 0; i < 15; i++)
            head_pattern[32*i+:32] <= $random(seed);
        repeat (8) @(posedge sys_clk);
        arst_n <= 1'b1;
        @(posedge sys_clk);
        for (i = 0; i < 7; i++)
            rd(idx_t[i], 34'h0);
        $display("test reset values done");
        for (i = 0; i < 7; i++)
        begin
            regs[i] = $random(seed);
            bus(1'b1, idx_t[i], regs[i]);
            rd(idx_t[i], {18'h0, (i == 6) ? (regs[i] & 16'h003F) : regs[i]});
        end
        bus(1'b1, 10'h160, 16'hFFFF);
        rd(10'h160, {2'b11, 32'h0});
        avs_byteenable <= 4'h2;
        bus(1'b1, IDX_START_POINT, ~regs[6]);
        avs_byteenable <= 4'hF;
        rd(IDX_START_POINT, {18'h0, regs[6] & 16'h003F});
        chk(tail_pattern, {regs[1], regs[0]});
        chk(byte_mask, {regs[5], regs[4], regs[3], regs[2]});
        $display("test register access done");
        for (i = 2; i < 6; i++)
        begin
            regs[i] = 16'h0000;
            bus(1'b1, idx_t[i], 16'h0000);
        end
        for (i = 0; i < 3; i++)
        begin
            sp = (i == 0) ? 6'h00 : (i == 1) ? 6'h3F : $random(seed);
            bus(1'b1, IDX_START_POINT, {10'h3FF, sp});
            frame(-1, -1, 1'b1);
            frame(60 + i, -1, 1'b0);
        end
        $display("test start point done");
        for (i = 0; i < 4; i++)
        begin
            b = 16 * i + ({$random(seed)} % 16);
            bus(1'b1, idx_t[2+i], 16'h0001 << (b % 16));
            frame(b, -1, 1'b1);
            frame(b ^ 1, -1, 1'b0);
            bus(1'b1, idx_t[2+i], 16'h0000);
        end
        for (i = 2; i < 6; i++)
            bus(1'b1, idx_t[i], 16'hFFFF);
        repeat (2) @(posedge sys_clk);
        chk(byte_mask, 64'hFFFF_FFFF_FFFF_FFFF);
        frame(7, -1, 1'b1);
        for (i = 2; i < 6; i++)
            bus(1'b1, idx_t[i], 16'h0000);
        $display("test byte masks done");
        frame(-1, 30, 1'b0);
        frame(-1, -1, 1'b1);
        $display("test abort done");
        chk(rd_q.size(), 64'h0);
        wrap_up();
    end
endmodule
